// *** logic/poc_ocw_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// operational command words of a master and slave controller pair
module poc_ocw_top
   import poc_pkg::*;
(
   input wire logic mclk_in, // system clock
   input wire logic srst_in, // synchronous reset, also bus reset
   input wire logic [15:0] io_addr_in, // port address
   input wire logic io_wr_in, // port write strobe
   input wire logic io_rd_in, // port read strobe
   input wire logic [7:0] io_wdata_in, // port write data
   input wire logic [15:0] irr_in, // request latches, slave high
   input wire logic [15:0] isr_in, // in-service latches, slave high
   input wire logic [1:0] inta_done_in, // auto end happened
   input wire logic [5:0] inta_lvl_in, // level of that auto end
   output logic [7:0] io_rdata_out, // read data for even ports
   output logic io_rdata_vld_out, // read data valid pulse
   output logic [15:0] isr_clr_out, // in-service clear pulses
   output logic [5:0] prio_low_out, // lowest-priority level each
   output logic [1:0] special_mask_out, // special mask mode each
   output logic [1:0] rot_aeoi_out, // rotate on auto end each
   output logic [1:0] poll_ack_out, // poll acknowledge pulse
   output logic [5:0] poll_lvl_out // level acknowledged by poll
);

   typedef struct packed {
      logic [1:0][2:0] low_lvl;
      logic [1:0] rot_aeoi;
      logic [1:0] special_mask_flag;
      logic [1:0] rd_isr;
      logic [1:0] poll_pend;
      logic [7:0] rdata;
      logic rdata_vld;
      logic [15:0] isr_clr;
      logic [1:0] poll_ack;
      logic [1:0][2:0] poll_lvl;
   } poc_state_t;

   poc_state_t st;
   poc_state_t next_st;

   // one-hot mask of a level
   function automatic logic [7:0] lvl_mask(input logic [2:0] lvl);
      lvl_mask = 8'h01 << lvl;
   endfunction

   // port address of a controller
   function automatic logic [15:0] ctrl_port(input int c);
      ctrl_port = (c == 0) ? MASTER_PORT : SLAVE_PORT;
   endfunction

   // resolver results, per controller
   logic [1:0] isr_hit;
   logic [1:0][2:0] isr_lvl;
   logic [1:0] irr_hit;
   logic [1:0][2:0] irr_lvl;

   poc_res_if isr_res[NUM_CTRL] ();
   poc_res_if irr_res[NUM_CTRL] ();

   // one resolver each for in-service and request latch
   for (genvar g = 0; g < NUM_CTRL; g++) begin : g_res
      assign isr_res[g].req = isr_in[g*8 +: 8];
      assign isr_res[g].low = st.low_lvl[g];
      assign irr_res[g].req = irr_in[g*8 +: 8];
      assign irr_res[g].low = st.low_lvl[g];
      assign isr_hit[g] = isr_res[g].hit;
      assign isr_lvl[g] = isr_res[g].lvl;
      assign irr_hit[g] = irr_res[g].hit;
      assign irr_lvl[g] = irr_res[g].lvl;
      poc_prio_res u_isr_res (
         .res (isr_res[g])
      );
      poc_prio_res u_irr_res (
         .res (irr_res[g])
      );
   end

   // command decode and read path
   always_comb begin
      logic wr_hit;
      logic rd_hit;
      logic [2:0] cmd;
      logic [2:0] lvl;
      logic [7:0] clr;
      wr_hit = 1'b0;
      rd_hit = 1'b0;
      cmd = 3'h0;
      lvl = 3'h0;
      clr = 8'h00;
      next_st = st;
      next_st.rdata_vld = 1'b0;
      next_st.isr_clr = 16'h0000;
      next_st.poll_ack = 2'h0;
      for (int c = 0; c < NUM_CTRL; c++) begin
         wr_hit = io_wr_in && (io_addr_in == ctrl_port(c));
         rd_hit = io_rd_in && (io_addr_in == ctrl_port(c));
         cmd = io_wdata_in[CMD_HI:CMD_LO];
         lvl = io_wdata_in[2:0];
         clr = 8'h00;
         // auto end rotates when the rotate mode is on
         if (inta_done_in[c] && st.rot_aeoi[c]) begin
            next_st.low_lvl[c] = inta_lvl_in[c*3 +: 3];
         end
         if (wr_hit && io_wdata_in[INIT_BIT]) begin
            // init word restarts the operational state
            next_st.low_lvl[c] = LOW_LVL_RST;
            next_st.rot_aeoi[c] = 1'b0;
            next_st.special_mask_flag[c] = 1'b0;
            next_st.rd_isr[c] = 1'b0;
            next_st.poll_pend[c] = 1'b0;
         end else if (wr_hit &&
               io_wdata_in[SEL_HI:SEL_LO] == SEL_ROT_EOI) begin
            case (cmd)
               CMD_NS_EOI: begin
                  // level bits unused here, winner comes from the latch
                  if (isr_hit[c]) begin
                     clr = lvl_mask(isr_lvl[c]);
                  end
               end
               CMD_SP_EOI: begin
                  clr = lvl_mask(lvl);
               end
               CMD_ROT_NS_EOI: begin
                  if (isr_hit[c]) begin
                     clr = lvl_mask(isr_lvl[c]);
                     next_st.low_lvl[c] = isr_lvl[c];
                  end
               end
               CMD_AEOI_SET: begin
                  next_st.rot_aeoi[c] = 1'b1;
               end
               CMD_AEOI_CLR: begin
                  next_st.rot_aeoi[c] = 1'b0;
               end
               CMD_ROT_SP_EOI: begin
                  clr = lvl_mask(lvl);
                  next_st.low_lvl[c] = lvl;
               end
               CMD_SET_PRIO: begin
                  next_st.low_lvl[c] = lvl;
               end
               CMD_NOP: begin
                  clr = 8'h00;
               end
               default: begin
                  clr = 8'h00;
               end
            endcase
         end else if (wr_hit &&
               io_wdata_in[SEL_HI:SEL_LO] == SEL_MASK_POLL) begin
            // special mask changes only through the gate
            if (io_wdata_in[SPECIAL_MASK_ENABLE_GATE_BIT]) begin
               next_st.special_mask_flag[c] = io_wdata_in[SMM_BIT];
            end
            if (io_wdata_in[POLL_BIT]) begin
               next_st.poll_pend[c] = 1'b1;
            end
            if (io_wdata_in[RD_EN_BIT]) begin
               next_st.rd_isr[c] = io_wdata_in[RD_ISR_BIT];
            end
         end
         next_st.isr_clr[c*8 +: 8] = clr;
         // even-port read: poll answer or selected latch
         if (rd_hit) begin
            next_st.rdata_vld = 1'b1;
            if (st.poll_pend[c]) begin
               next_st.poll_pend[c] = 1'b0;
               next_st.rdata = {irr_hit[c], 4'h0, irr_lvl[c]};
               next_st.poll_ack[c] = irr_hit[c];
               next_st.poll_lvl[c] = irr_lvl[c];
            end else if (st.rd_isr[c]) begin
               next_st.rdata = isr_in[c*8 +: 8];
            end else begin
               next_st.rdata = irr_in[c*8 +: 8];
            end
         end
      end
   end

   // state register with reset to fully nested operation
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         st.low_lvl <= {LOW_LVL_RST, LOW_LVL_RST};
         st.rot_aeoi <= 2'h0;
         st.special_mask_flag <= 2'h0;
         st.rd_isr <= 2'h0;
         st.poll_pend <= 2'h0;
         st.rdata <= 8'h00;
         st.rdata_vld <= 1'b0;
         st.isr_clr <= 16'h0000;
         st.poll_ack <= 2'h0;
         st.poll_lvl <= 6'h00;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state flops
   assign io_rdata_out = st.rdata;
   assign io_rdata_vld_out = st.rdata_vld;
   assign isr_clr_out = st.isr_clr;
   assign prio_low_out = st.low_lvl;
   assign special_mask_out = st.special_mask_flag;
   assign rot_aeoi_out = st.rot_aeoi;
   assign poll_ack_out = st.poll_ack;
   assign poll_lvl_out = st.poll_lvl;

endmodule
`default_nettype wire

// *** logic/poc_pkg.sv ***
package poc_pkg;
   // even command ports of the two controllers
   localparam logic [15:0] MASTER_PORT = 16'h0020;
   localparam logic [15:0] SLAVE_PORT = 16'h00A0;
   localparam int NUM_CTRL = 2;
   localparam int NUM_LVL = 8;
   // command word field positions
   localparam int CMD_HI = 7;
   localparam int CMD_LO = 5;
   localparam int LVL_SEL_BIT = 6;
   localparam int SEL_HI = 4;
   localparam int SEL_LO = 3;
   localparam int INIT_BIT = 4;
   localparam int SMM_BIT = 6;
   localparam int SPECIAL_MASK_ENABLE_GATE_BIT = 5;
   localparam int POLL_BIT = 2;
   localparam int RD_EN_BIT = 1;
   localparam int RD_ISR_BIT = 0;
   // word select patterns in bits 4:3
   localparam logic [1:0] SEL_ROT_EOI = 2'h0;
   localparam logic [1:0] SEL_MASK_POLL = 2'h1;
   // rotate and end-of-interrupt command codes
   localparam logic [2:0] CMD_AEOI_CLR = 3'h0;
   localparam logic [2:0] CMD_NS_EOI = 3'h1;
   localparam logic [2:0] CMD_NOP = 3'h2;
   localparam logic [2:0] CMD_SP_EOI = 3'h3;
   localparam logic [2:0] CMD_AEOI_SET = 3'h4;
   localparam logic [2:0] CMD_ROT_NS_EOI = 3'h5;
   localparam logic [2:0] CMD_SET_PRIO = 3'h6;
   localparam logic [2:0] CMD_ROT_SP_EOI = 3'h7;
   // lowest-priority level after reset, level 0 then highest
   localparam logic [2:0] LOW_LVL_RST = 3'h7;
   // poll answer layout
   localparam int POLL_HIT_BIT = 7;
endpackage

// *** logic/poc_prio_res.sv ***
`timescale 1ns/10ps
`default_nettype none
// finds the highest-priority set bit, counting upward after low
module poc_prio_res
   import poc_pkg::*;
(
   poc_res_if.resolver res // latch in, winning level out
);
   logic [2:0] idx;
   // scan downward so the nearest level after low wins
   always_comb begin
      idx = 3'h0;
      res.hit = 1'b0;
      res.lvl = 3'h0;
      for (int i = NUM_LVL - 1; i >= 0; i--) begin
         idx = 3'(res.low + 3'(i) + 3'h1);
         if (res.req[idx]) begin
            res.hit = 1'b1;
            res.lvl = idx;
         end
      end
   end
endmodule
`default_nettype wire

// *** logic/poc_res_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// carries one latch and its rotation base to a priority resolver
interface poc_res_if;
   logic [7:0] req;
   logic [2:0] low;
   logic hit;
   logic [2:0] lvl;
   modport client (output req, output low, input hit, input lvl);
   modport resolver (input req, input low, output hit, output lvl);
endinterface
`default_nettype wire

// *** tb/poc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// host issuing port cycles; released lines show inverted values
module poc_host (
   input wire logic mclk_in, // clock
   input wire logic [7:0] rdata_in, // read data
   output logic [15:0] addr_out, // port
   output logic wr_out, // write strobe
   output logic rd_out, // read strobe
   output logic [7:0] wdata_out // write data
);
   // idle bus at time zero
   initial begin
      addr_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 8'h00;
   end
   // one write cycle
   task automatic wr(input logic [15:0] p, input logic [7:0] d);
      @(negedge mclk_in);
      addr_out = p;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge mclk_in);
      wr_out = 1'b0;
      wdata_out = ~d;
      addr_out = ~p;
   endtask
   // rotate and end word
   task automatic rot(input logic [15:0] p, input logic [5:0] c);
      wr(p, {c[5:3], 2'h0, c[2:0]});
   endtask
   // mask, poll and read word
   task automatic ctl(input logic [15:0] p, input logic [4:0] b);
      wr(p, {1'b0, b[4:3], 2'h1, b[2:0]});
   endtask
   // one read cycle, data taken with the valid pulse
   task automatic rd(input logic [15:0] p, output logic [7:0] q);
      @(negedge mclk_in);
      addr_out = p;
      rd_out = 1'b1;
      @(negedge mclk_in);
      rd_out = 1'b0;
      addr_out = ~p;
      q = rdata_in;
   endtask
endmodule
`default_nettype wire

// *** tb/poc_ocw_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// checks master command-word effects at the top ports
module poc_ocw_sva (
   input wire logic mclk_in, // clock
   input wire logic srst_in, // reset
   input wire logic [15:0] io_addr_in, // port
   input wire logic io_wr_in, // write
   input wire logic io_rd_in, // read
   input wire logic [7:0] io_wdata_in, // data
   input wire logic [15:0] isr_in, // in-service
   input wire logic [1:0] inta_done_in, // auto end
   input wire logic [5:0] inta_lvl_in, // auto level
   input wire logic [7:0] io_rdata_out, // read data
   input wire logic io_rdata_vld_out, // read valid
   input wire logic [15:0] isr_clr_out, // clears
   input wire logic [5:0] prio_low_out, // lowest level
   input wire logic [1:0] special_mask_out, // mask mode
   input wire logic [1:0] rot_aeoi_out, // auto rotate
   input wire logic [1:0] poll_ack_out // poll ack
);
   // master write decode and expected clear patterns
   wire logic m_wr = io_wr_in && io_addr_in == 16'h0020;
   wire logic m_rot = m_wr && io_wdata_in[4:3] == 2'h0;
   wire logic m_ctl = m_wr && io_wdata_in[4:3] == 2'h1;
   wire logic [7:0] m_lsb = isr_in[7:0] & (~isr_in[7:0] + 8'h01);
   wire logic [7:0] m_sel = 8'h01 << io_wdata_in[2:0];
   default clocking dc @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   rd_valid_a: assert property (
      io_rdata_vld_out |-> $past(io_rd_in)) else $error("stray valid");
   nseoi_clear_a: assert property (
      m_rot && io_wdata_in[7:5] == 3'h1 && prio_low_out[2:0] == 3'h7
      |=> isr_clr_out[7:0] == $past(m_lsb)) else $error("bad clear");
   speoi_clear_a: assert property (
      m_rot && io_wdata_in[7:5] == 3'h3
      |=> isr_clr_out[7:0] == $past(m_sel)) else $error("bad level");
   aeoi_mode_a: assert property (
      m_rot && io_wdata_in[6:5] == 2'h0
      |=> rot_aeoi_out[0] == $past(io_wdata_in[7])) else $error("aeoi");
   set_prio_a: assert property (
      m_rot && io_wdata_in[7:6] == 2'h3
      |=> prio_low_out[2:0] == $past(io_wdata_in[2:0])) else $error("prio");
   smm_set_a: assert property (
      m_ctl && io_wdata_in[5]
      |=> special_mask_out[0] == $past(io_wdata_in[6])) else $error("smm");
   smm_keep_a: assert property (
      m_ctl && !io_wdata_in[5] |=> $stable(special_mask_out[0]))
      else $error("smm kept");
   poll_ack_a: assert property (
      poll_ack_out[0] |-> io_rdata_vld_out && io_rdata_out[7])
      else $error("poll ack");
   auto_rot_a: assert property (
      inta_done_in[0] && rot_aeoi_out[0] && !io_wr_in
      |=> prio_low_out[2:0] == $past(inta_lvl_in[2:0])) else $error("rot");
endmodule
`default_nettype wire

// *** tb/poc_ocw_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module poc_ocw_top_tb;
   import poc_pkg::*;
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [15:0] irr_in = 16'h0000, isr_in = 16'h0000, io_addr_in, isr_clr_out;
   logic [1:0] inta_done_in = 2'h0, special_mask_out, rot_aeoi_out, poll_ack_out;
   logic [5:0] inta_lvl_in = 6'h00, prio_low_out, poll_lvl_out;
   logic [7:0] io_wdata_in, io_rdata_out, q;
   logic io_wr_in, io_rd_in, io_rdata_vld_out;
   int n_mismatch = 0;
   int samples_checked = 0;
   poc_ocw_top dut_u (.mclk_in, .srst_in, .io_addr_in, .io_wr_in, .io_rd_in,
      .io_wdata_in, .irr_in, .isr_in, .inta_done_in, .inta_lvl_in,
      .io_rdata_out, .io_rdata_vld_out, .isr_clr_out, .prio_low_out,
      .special_mask_out, .rot_aeoi_out, .poll_ack_out, .poll_lvl_out);
   poc_host host_u (.mclk_in, .rdata_in(io_rdata_out), .addr_out(io_addr_in),
      .wr_out(io_wr_in), .rd_out(io_rd_in), .wdata_out(io_wdata_in));
   // compare and count
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // verdict
   task automatic conclude();
      if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one auto end pulse on the master
   task automatic ae(input logic [2:0] l);
      @(negedge mclk_in);
      inta_lvl_in = {3'h0, l};
      inta_done_in = 2'h1;
      @(negedge mclk_in);
      inta_done_in = 2'h0;
   endtask
   // status reads and poll
   task automatic t_read();
      irr_in = 16'hA55A;
      isr_in = 16'h0C30;
      host_u.rd(MASTER_PORT, q); chk({io_rdata_vld_out, q}, {1'b1, 8'h5A});
      host_u.ctl(MASTER_PORT, 5'h03); host_u.rd(MASTER_PORT, q); chk(q, 8'h30);
      host_u.ctl(MASTER_PORT, 5'h00); host_u.rd(MASTER_PORT, q); chk(q, 8'h30);
      host_u.ctl(MASTER_PORT, 5'h04); host_u.rd(MASTER_PORT, q);
      chk({poll_ack_out, q}, {2'h1, 8'h81});
      host_u.rd(MASTER_PORT, q); chk(q, 8'h30);
      host_u.ctl(SLAVE_PORT, 5'h04); host_u.rd(SLAVE_PORT, q); chk(q, 8'h80);
      chk({poll_ack_out, poll_lvl_out}, {2'h2, 6'h01});
   endtask
   // end commands and rotation
   task automatic t_eoi();
      isr_in = 16'h0C0C;
      host_u.rot(MASTER_PORT, 6'h15); chk(isr_clr_out, 0);
      host_u.rot(MASTER_PORT, 6'h0B); chk(isr_clr_out, 16'h0004);
      host_u.rot(SLAVE_PORT, 6'h1B); chk(isr_clr_out, 16'h0800);
      host_u.rot(MASTER_PORT, 6'h28); chk({prio_low_out, isr_clr_out}, {6'h3A, 16'h0004});
      host_u.rot(MASTER_PORT, 6'h08); chk(isr_clr_out, 16'h0008);
      host_u.rot(MASTER_PORT, 6'h3B); chk({prio_low_out, isr_clr_out}, {6'h3B, 16'h0008});
      host_u.rot(SLAVE_PORT, 6'h35); chk(prio_low_out, 6'h2B);
   endtask
   // automatic-end rotation mode, mask mode, then init
   task automatic t_modes();
      host_u.rot(MASTER_PORT, 6'h20); chk(rot_aeoi_out, 2'h1);
      ae(3'h4); chk(prio_low_out, 6'h2C);
      host_u.rot(MASTER_PORT, 6'h00); ae(3'h1); chk({rot_aeoi_out, prio_low_out}, 8'h2C);
      host_u.ctl(MASTER_PORT, 5'h18); chk(special_mask_out, 2'h1);
      host_u.ctl(MASTER_PORT, 5'h00); host_u.ctl(SLAVE_PORT, 5'h10); chk(special_mask_out, 2'h1);
      host_u.ctl(MASTER_PORT, 5'h08); chk(special_mask_out, 2'h0);
      host_u.ctl(MASTER_PORT, 5'h1B); host_u.rot(MASTER_PORT, 6'h20); host_u.wr(MASTER_PORT, 8'h11);
      host_u.rd(MASTER_PORT, q); chk({special_mask_out, rot_aeoi_out, prio_low_out, q}, 18'h02F5A);
   endtask
   // clock
   initial forever #4 mclk_in = ~mclk_in;
   // main sequence
   initial begin
      repeat (3) @(negedge mclk_in);
      srst_in = 1'b0;
      chk({special_mask_out, rot_aeoi_out, prio_low_out}, 10'h03F);
      t_read();
      t_eoi();
      t_modes();
      conclude();
   end
   // watchdog
   initial begin
      repeat (2000) @(posedge mclk_in);
      n_mismatch++;
      conclude();
   end
endmodule
bind poc_ocw_top poc_ocw_sva sva_u (.mclk_in, .srst_in, .io_addr_in,
   .io_wr_in, .io_rd_in, .io_wdata_in, .isr_in, .inta_done_in, .inta_lvl_in,
   .io_rdata_out, .io_rdata_vld_out, .isr_clr_out, .prio_low_out,
   .special_mask_out, .rot_aeoi_out, .poll_ack_out);
`default_nettype wire
